// *** interrupt_enable_flag_control_tb.sv ***
// self-checking bench for the interrupt enable/flag block
// assumes the source model drives every event line; the bench owns the register port
`timescale 1ns/10ps
module interrupt_enable_flag_control_tb;
    import irq_ctrl_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [3:0] pc_en = 4'h0;                  // per-pin change enables
    logic [7:0] reg_rdata_o;
    logic t0, ext, core_irq, evt_irq;
    logic [3:0] pins;
    logic [7:0] req;
    int num_errors = 0;
    int num_checks = 0;
    irq_source_model irq_source_model_i (.clk_sys_i(clk_sys_i), .timer0_rollover_o(t0),
        .ext_pin_o(ext), .pin_level_o(pins), .periph_req_o(req));
    irq_enable_flag_ctrl #(.PIN_COUNT(4)) irq_enable_flag_ctrl_i (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .timer0_rollover_i(t0), .ext_pin_i(ext), .pin_change_in_i(pins),
        .per_pin_change_enables_i(pc_en), .periph_req_flags_i(req),
        .core_irq_req_o(core_irq), .evt_irq_o(evt_irq));
    // 100 ns clock
    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // compare and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    // read strobe, data looked at in the following cycle only, under a bit mask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("reg_rdata_o", reg_rdata_o & m, exp);
    endtask : rd
    // core request level once the last edge has landed
    task automatic ci(input logic v);
        @(negedge clk_sys_i);
        chk("core_irq_req_o", {7'h00, core_irq}, {7'h00, v});
    endtask : ci
    // lines settle through edge detection
    task automatic gap();
        repeat (3) @(posedge clk_sys_i);
    endtask : gap
    task automatic t_reset();
        rd(CTRL_FLAGS_ADDR, 8'h00, 8'hFE);
        rd(PERIPH_EN_ADDR, 8'h00, 8'hFF);
        rd(8'h55, 8'h00, 8'hFF);
        $display("test reset done");
    endtask : t_reset
    task automatic t_timer();
        irq_source_model_i.pulse_timer0();
        rd(CTRL_FLAGS_ADDR, 8'h04, 8'hFE);
        ci(1'b0);
        wr(CTRL_FLAGS_ADDR, 8'hA4);
        ci(1'b1);
        wr(CTRL_FLAGS_ADDR, 8'h24);
        ci(1'b0);
        wr(CTRL_FLAGS_ADDR, 8'h80);
        rd(CTRL_FLAGS_ADDR, 8'h80, 8'hFE);
        $display("test timer done");
    endtask : t_timer
    task automatic t_ext();
        wr(CTRL_FLAGS_ADDR, 8'h90);
        irq_source_model_i.drive_lines(1'b1, 4'h0, 8'h00);
        gap();
        ci(1'b1);
        repeat (20) @(posedge clk_sys_i);
        rd(CTRL_FLAGS_ADDR, 8'h92, 8'hFE);
        wr(CTRL_FLAGS_ADDR, 8'h90);
        irq_source_model_i.drive_lines(1'b0, 4'h0, 8'h00);
        gap();
        rd(CTRL_FLAGS_ADDR, 8'h90, 8'hFE);
        wr(OPTION_ADDR, 8'h00);
        irq_source_model_i.drive_lines(1'b1, 4'h0, 8'h00);
        gap();
        rd(CTRL_FLAGS_ADDR, 8'h90, 8'hFE);
        irq_source_model_i.drive_lines(1'b0, 4'h0, 8'h00);
        gap();
        rd(CTRL_FLAGS_ADDR, 8'h92, 8'hFE);
        wr(OPTION_ADDR, 8'h01);
        wr(CTRL_FLAGS_ADDR, 8'h00);
        $display("test external done");
    endtask : t_ext
    task automatic t_pc();
        pc_en <= 4'hF;
        wr(CTRL_FLAGS_ADDR, 8'h08);
        irq_source_model_i.drive_lines(1'b0, 4'h1, 8'h00);
        gap();
        rd(CTRL_FLAGS_ADDR, 8'h09, 8'hFF);
        wr(CTRL_FLAGS_ADDR, 8'h89);
        ci(1'b1);
        wr(CTRL_FLAGS_ADDR, 8'h88);
        gap();
        rd(CTRL_FLAGS_ADDR, 8'h88, 8'hFF);
        pc_en <= 4'h0;
        irq_source_model_i.drive_lines(1'b0, 4'h0, 8'h00);
        gap();
        ci(1'b0);
        wr(CTRL_FLAGS_ADDR, 8'h00);
        $display("test pin change done");
    endtask : t_pc
    task automatic t_periph();
        wr(PERIPH_EN_ADDR, 8'h80);
        rd(PERIPH_EN_ADDR, 8'h80, 8'hFF);
        irq_source_model_i.drive_lines(1'b0, 4'h0, 8'h80);
        rd(PERIPH_REQ_ADDR, 8'h80, 8'hFF);
        wr(CTRL_FLAGS_ADDR, 8'h80);
        ci(1'b0);
        wr(CTRL_FLAGS_ADDR, 8'h40);
        ci(1'b0);
        wr(CTRL_FLAGS_ADDR, 8'hC0);
        ci(1'b1);
        for (int i = 0; i < 8; i++) begin
            irq_source_model_i.drive_lines(1'b0, 4'h0, 8'h01 << i);
            wr(PERIPH_EN_ADDR, 8'h01 << i);
            ci(1'b1);
            wr(PERIPH_EN_ADDR, ~(8'h01 << i));
            ci(1'b0);
        end
        irq_source_model_i.drive_lines(1'b0, 4'h0, 8'h00);
        wr(CTRL_FLAGS_ADDR, 8'h00);
        $display("test peripheral done");
    endtask : t_periph
    task automatic t_evt();
        wr(EVT_STATUS_ADDR, 8'hFF);
        rd(EVT_STATUS_ADDR, 8'h00, 8'hFF);
        irq_source_model_i.pulse_timer0();
        rd(EVT_STATUS_ADDR, 8'h01, 8'hFF);
        wr(EVT_MASK_ADDR, 8'hFE);
        @(negedge clk_sys_i);
        chk("evt_irq_o masked", {7'h00, evt_irq}, 8'h00);
        wr(EVT_MASK_ADDR, 8'h01);
        @(negedge clk_sys_i);
        chk("evt_irq_o unmasked", {7'h00, evt_irq}, 8'h01);
        wr(EVT_STATUS_ADDR, 8'h01);
        @(negedge clk_sys_i);
        chk("evt_irq_o", {7'h00, evt_irq}, 8'h00);
        rd(EVT_STATUS_ADDR, 8'h00, 8'hFF);
        $display("test event status done");
    endtask : t_evt
    // counts, verdict, end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    // watchdog, well past the few hundred cycles the tests need
    initial begin
        #2000000;
        num_errors++;
        stop_test();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_timer();
        t_ext();
        t_pc();
        t_periph();
        t_evt();
        stop_test();
    end
endmodule : interrupt_enable_flag_control_tb

// *** irq_ctrl_pkg.sv ***
// register map, field positions and reset values of the core interrupt control block
// assumes one 8-bit register port and one system clock
package irq_ctrl_pkg;
    localparam int ADDR_W = 8;                                      // register address width
    localparam int DATA_W = 8;                                      // register data width
    localparam logic [7:0] CTRL_FLAGS_ADDR = 8'h0B;                 // core control/flag register
    localparam logic [7:0] PERIPH_EN_ADDR = 8'h87;                  // first peripheral enable
    localparam logic [7:0] PERIPH_REQ_ADDR = 8'h0C;                 // peripheral request mirror
    localparam logic [7:0] EVT_STATUS_ADDR = 8'h90;                 // sticky event status
    localparam logic [7:0] EVT_MASK_ADDR = 8'h91;                   // event interrupt mask
    localparam logic [7:0] OPTION_ADDR = 8'h92;                     // edge select option
    localparam int GLOBAL_EN_BIT = 7;                               // global enable position
    localparam int PERIPH_GATE_BIT = 6;                             // peripheral gate position
    localparam int T0_EN_BIT = 5;                                   // timer0 enable position
    localparam int EXT_EN_BIT = 4;                                  // external enable position
    localparam int PC_EN_BIT = 3;                                   // pin-change enable position
    localparam int T0_FLAG_BIT = 2;                                 // timer0 flag position
    localparam int EXT_FLAG_BIT = 1;                                // external flag position
    localparam int PC_FLAG_BIT = 0;                                 // pin-change flag position
    localparam int OVERTEMP_BIT = 7;                                // over-temperature enable
    localparam int EDGE_SEL_BIT = 0;                                // edge select in option reg
    localparam logic [6:0] CTRL_RESET = 7'h00;                      // bits 7..1 reset value
    localparam logic [7:0] PERIPH_EN_RESET = 8'h00;                 // peripheral enable reset
    localparam logic [7:0] EVT_RESET = 8'h00;                       // status and mask reset
    localparam logic [7:0] OPTION_RESET = 8'h01;                    // rising edge after reset
endpackage : irq_ctrl_pkg

// *** irq_enable_flag_ctrl.sv ***
// core interrupt control/flag register, first peripheral enable register and request gating
// assumes synchronous inputs, a plain register port and the core sampling core_irq_req_o
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module irq_enable_flag_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int PIN_COUNT = 4                                     // pin-change inputs watched
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [irq_ctrl_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [irq_ctrl_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [irq_ctrl_pkg::DATA_W-1:0] reg_rdata_o,
    // event sources
    input wire logic timer0_rollover_i,
    input wire logic ext_pin_i,
    input wire logic [PIN_COUNT-1:0] pin_change_in_i,
    input wire logic [PIN_COUNT-1:0] per_pin_change_enables_i,
    input wire logic [7:0] periph_req_flags_i,
    // outputs to the core
    output logic core_irq_req_o,
    output logic evt_irq_o
);
    import irq_ctrl_pkg::*;

    initial begin
        if (PIN_COUNT < 1 || PIN_COUNT > 8) begin
            $error("PIN_COUNT must be 1 to 8");
        end
    end

    logic global_irq_enable;                                        // bit 7
    logic peripheral_irq_gate;                                      // bit 6
    logic timer0_overflow_irq_enable;                               // bit 5
    logic ext_pin_irq_enable;                                       // bit 4
    logic pin_change_irq_enable;                                    // bit 3
    logic timer0_overflow_flag;                                     // bit 2, sticky
    logic ext_pin_irq_flag;                                         // bit 1, sticky
    logic pin_change_irq_flag;                                      // bit 0, sticky
    logic [7:0] peripheral_irq_enable_one;                          // enables at 87h
    logic ext_edge_select;                                          // 1 rising, 0 falling
    logic ext_pin_prev;                                             // last pin sample
    logic [PIN_COUNT-1:0] pin_prev;                                 // last pin-change samples
    logic pin_prev_valid;                                           // samples hold real history
    logic [7:0] evt_status;                                         // sticky event status
    logic [7:0] evt_mask;                                           // event mask
    logic ext_edge_seen;                                            // qualified edge this cycle
    logic pin_change_seen;                                          // any watched pin changed
    logic periph_any;                                               // any enabled peripheral req
    logic next_core_irq;                                            // combined request
    logic wr_ctrl;                                                  // write to control/flags
    logic [7:0] ctrl_read;                                          // assembled control byte
    logic [7:0] evt_set;                                            // status set this cycle

    // edge detection; the history is held only once a first sample exists,
    // so a pin that idles high cannot fake an edge right after reset
    assign ext_edge_seen = pin_prev_valid & (ext_edge_select ? (ext_pin_i & ~ext_pin_prev)
                                           : (~ext_pin_i & ext_pin_prev));
    assign pin_change_seen = pin_prev_valid &
        (|((pin_change_in_i ^ pin_prev) & per_pin_change_enables_i));

    // peripheral requests only count through their own enable
    assign periph_any = |(peripheral_irq_enable_one & periph_req_flags_i);

    // the core request; enables only gate, flags never depend on them
    assign next_core_irq = global_irq_enable & (
        (timer0_overflow_irq_enable & timer0_overflow_flag) |
        (ext_pin_irq_enable & ext_pin_irq_flag) |
        (pin_change_irq_enable & pin_change_irq_flag) |
        (peripheral_irq_gate & periph_any));
    assign core_irq_req_o = next_core_irq;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == CTRL_FLAGS_ADDR);
    assign ctrl_read = {global_irq_enable, peripheral_irq_gate, timer0_overflow_irq_enable,
                        ext_pin_irq_enable, pin_change_irq_enable, timer0_overflow_flag,
                        ext_pin_irq_flag, pin_change_irq_flag};

    // pin sample history, used for both edge detectors
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_pin_prev <= 1'b0;
            pin_prev <= '0;
            pin_prev_valid <= 1'b0;
        end else begin
            ext_pin_prev <= ext_pin_i;
            pin_prev <= pin_change_in_i;
            pin_prev_valid <= 1'b1;
        end
    end

    // enable bits of the control register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {global_irq_enable, peripheral_irq_gate, timer0_overflow_irq_enable,
             ext_pin_irq_enable, pin_change_irq_enable} <= CTRL_RESET[6:2];
        end else if (wr_ctrl) begin
            global_irq_enable <= reg_wdata_i[GLOBAL_EN_BIT];
            peripheral_irq_gate <= reg_wdata_i[PERIPH_GATE_BIT];
            timer0_overflow_irq_enable <= reg_wdata_i[T0_EN_BIT];
            ext_pin_irq_enable <= reg_wdata_i[EXT_EN_BIT];
            pin_change_irq_enable <= reg_wdata_i[PC_EN_BIT];
        end
    end

    // flags: software writes the byte, but a new event in the same cycle wins
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer0_overflow_flag <= CTRL_RESET[1];
            ext_pin_irq_flag <= CTRL_RESET[0];
            pin_change_irq_flag <= 1'b0;                            // power-on value is free
        end else begin
            if (timer0_rollover_i) begin
                timer0_overflow_flag <= 1'b1;
            end else if (wr_ctrl) begin
                timer0_overflow_flag <= reg_wdata_i[T0_FLAG_BIT];
            end
            if (ext_edge_seen) begin
                ext_pin_irq_flag <= 1'b1;
            end else if (wr_ctrl) begin
                ext_pin_irq_flag <= reg_wdata_i[EXT_FLAG_BIT];
            end
            if (pin_change_seen) begin
                pin_change_irq_flag <= 1'b1;
            end else if (wr_ctrl) begin
                pin_change_irq_flag <= reg_wdata_i[PC_FLAG_BIT];
            end
        end
    end

    // peripheral enables and edge option
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            peripheral_irq_enable_one <= PERIPH_EN_RESET;
            ext_edge_select <= OPTION_RESET[EDGE_SEL_BIT];
        end else begin
            if (reg_wr_i && reg_addr_i == PERIPH_EN_ADDR) begin
                peripheral_irq_enable_one <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == OPTION_ADDR) begin
                ext_edge_select <= reg_wdata_i[EDGE_SEL_BIT];
            end
        end
    end

    // event status: bit0 timer0, bit1 ext edge, bit2 pin change, bit3 core request rise
    logic core_req_q;                                               // previous core request
    assign evt_set = {4'h0, next_core_irq & ~core_req_q, pin_change_seen, ext_edge_seen,
                      timer0_rollover_i};

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            evt_status <= EVT_RESET;
            evt_mask <= EVT_RESET;
            core_req_q <= 1'b0;
        end else begin
            core_req_q <= next_core_irq;
            // write-one-to-clear, a same-cycle set wins
            if (reg_wr_i && reg_addr_i == EVT_STATUS_ADDR) begin
                evt_status <= (evt_status & ~reg_wdata_i) | evt_set;
            end else begin
                evt_status <= evt_status | evt_set;
            end
            if (reg_wr_i && reg_addr_i == EVT_MASK_ADDR) begin
                evt_mask <= reg_wdata_i;
            end
        end
    end
    assign evt_irq_o = |(evt_status & evt_mask);

    // read data, one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                CTRL_FLAGS_ADDR: reg_rdata_o <= ctrl_read;
                PERIPH_EN_ADDR: reg_rdata_o <= peripheral_irq_enable_one;
                PERIPH_REQ_ADDR: reg_rdata_o <= periph_req_flags_i;
                EVT_STATUS_ADDR: reg_rdata_o <= evt_status;
                EVT_MASK_ADDR: reg_rdata_o <= evt_mask;
                OPTION_ADDR: reg_rdata_o <= {7'h00, ext_edge_select};
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // last write data, kept only so the checks can compare what landed
    logic [7:0] last_wdata;
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_wdata <= 8'h00;
        end else begin
            last_wdata <= reg_wdata_i;
        end
    end

    // checks
    AST_GLOBAL_BLOCKS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !global_irq_enable |-> !core_irq_req_o) else $error("request with global off");
    AST_PERIPH_GATE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (!peripheral_irq_gate && !(timer0_overflow_irq_enable && timer0_overflow_flag)
         && !(ext_pin_irq_enable && ext_pin_irq_flag)
         && !(pin_change_irq_enable && pin_change_irq_flag)) |-> !core_irq_req_o)
        else $error("peripheral request leaked");
    AST_PERIPH_PASS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (global_irq_enable && peripheral_irq_gate && periph_any) |-> core_irq_req_o)
        else $error("peripheral request lost");
    AST_T0_REQ: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (global_irq_enable && timer0_overflow_irq_enable && timer0_overflow_flag)
        |-> core_irq_req_o) else $error("timer0 request lost");
    AST_EXT_REQ: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (global_irq_enable && ext_pin_irq_enable && ext_pin_irq_flag) |-> core_irq_req_o)
        else $error("external request lost");
    AST_T0_STICKY: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        timer0_rollover_i |=> timer0_overflow_flag) else $error("timer0 flag not set");
    AST_EXT_HOLD: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (ext_pin_irq_flag && !wr_ctrl) |=> ext_pin_irq_flag) else $error("ext flag dropped");
    AST_EXT_RISE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (ext_edge_select && pin_prev_valid && $rose(ext_pin_i)) |=> ext_pin_irq_flag)
        else $error("rising edge missed");
    AST_PC_SET: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        pin_change_seen |=> pin_change_irq_flag) else $error("pin change missed");
    AST_OT_MASK: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (periph_req_flags_i == 8'h80 && !peripheral_irq_enable_one[OVERTEMP_BIT]) |-> !periph_any)
        else $error("overtemp not masked");

    // a falling edge sets the flag when falling edges are selected
    AST_EXT_FALL: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (!ext_edge_select && pin_prev_valid && $fell(ext_pin_i)) |=> ext_pin_irq_flag)
        else $error("falling edge missed");

    // a falling edge must never count while rising edges are selected
    AST_EXT_WRONG_EDGE: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (ext_edge_select && $fell(ext_pin_i)) |-> !ext_edge_seen)
        else $error("wrong edge taken");

    // a zero written to the external flag clears it when no edge competes
    AST_EXT_CLEAR: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (wr_ctrl && !reg_wdata_i[EXT_FLAG_BIT] && !ext_edge_seen) |=> !ext_pin_irq_flag)
        else $error("ext flag not cleared");

    // an edge in the cycle of a clearing write still sets the flag
    AST_EXT_SET_WINS: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (wr_ctrl && ext_edge_seen) |=> ext_pin_irq_flag)
        else $error("ext edge lost to write");

    // the timer0 flag only falls through a register write
    AST_T0_HOLD: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (timer0_overflow_flag && !wr_ctrl) |=> timer0_overflow_flag)
        else $error("timer0 flag dropped");

    // software clears the timer0 flag by writing zero
    AST_T0_CLEAR: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (wr_ctrl && !reg_wdata_i[T0_FLAG_BIT] && !timer0_rollover_i) |=> !timer0_overflow_flag)
        else $error("timer0 flag not cleared");

    // the pin-change flag is sticky as well
    AST_PC_HOLD: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (pin_change_irq_flag && !wr_ctrl) |=> pin_change_irq_flag)
        else $error("pin change flag dropped");

    // with every per-pin enable off, no pin raises a change
    AST_PC_MASKED: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (per_pin_change_enables_i == '0) |-> !pin_change_seen)
        else $error("masked pin change seen");

    // an enabled pin-change flag reaches the core
    AST_PC_REQ: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (global_irq_enable && pin_change_irq_enable && pin_change_irq_flag) |-> core_irq_req_o)
        else $error("pin change request lost");

    // every core request has an enabled source behind it
    AST_REQ_SOURCE: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        core_irq_req_o |-> ((timer0_overflow_irq_enable && timer0_overflow_flag)
        || (ext_pin_irq_enable && ext_pin_irq_flag)
        || (pin_change_irq_enable && pin_change_irq_flag)
        || (peripheral_irq_gate && periph_any)))
        else $error("request without source");

    // the flag sets even with every enable off
    AST_FLAG_NO_ENABLE: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (timer0_rollover_i && !global_irq_enable && !timer0_overflow_irq_enable)
        |=> timer0_overflow_flag)
        else $error("flag waited for enable");

    // enable bits take the written byte
    AST_CTRL_WRITE: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        wr_ctrl |=> (ctrl_read[7:3] == last_wdata[7:3]))
        else $error("enable write lost");

    // the peripheral enable register takes the written byte
    AST_PERIPH_WRITE: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (reg_wr_i && reg_addr_i == PERIPH_EN_ADDR) |=> (peripheral_irq_enable_one == last_wdata))
        else $error("peripheral enable write lost");

    // reads of the enable register return it one cycle later
    AST_PERIPH_READ: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (reg_rd_i && reg_addr_i == PERIPH_EN_ADDR)
        |=> (reg_rdata_o == $past(peripheral_irq_enable_one)))
        else $error("peripheral enable read wrong");

    // reads of the control byte return it one cycle later
    AST_CTRL_READ: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (reg_rd_i && reg_addr_i == CTRL_FLAGS_ADDR) |=> (reg_rdata_o == $past(ctrl_read)))
        else $error("control read wrong");

    // the timer0 event status bit stays until written off
    AST_EVT_STICKY: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (evt_status[0] && !(reg_wr_i && reg_addr_i == EVT_STATUS_ADDR)) |=> evt_status[0])
        else $error("event status dropped");

    // an enabled over-temperature request counts as a peripheral request
    AST_OT_PASS: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (peripheral_irq_enable_one[OVERTEMP_BIT] && periph_req_flags_i[OVERTEMP_BIT])
        |-> periph_any)
        else $error("overtemp request lost");
    COV_T0_IRQ: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        timer0_rollover_i ##1 core_irq_req_o);
    COV_EXT_FALL: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !ext_edge_select && $fell(ext_pin_i) ##1 ext_pin_irq_flag);
    COV_PERIPH: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        peripheral_irq_gate && periph_any && core_irq_req_o);
    COV_PC_IRQ: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        pin_change_seen ##1 pin_change_irq_flag);
    COV_EXT_RISE: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        ext_edge_select && ext_edge_seen ##1 ext_pin_irq_flag);
endmodule : irq_enable_flag_ctrl

// *** irq_source_model.sv ***
// event source model: timer0 rollover, external pin, pin-change levels, peripheral requests
// assumes the bench calls its tasks, and one system clock
`timescale 1ns/10ps
module irq_source_model (
    // clock
    input wire logic clk_sys_i,
    // event lines toward the block
    output logic timer0_rollover_o,
    output logic ext_pin_o,
    output logic [3:0] pin_level_o,
    output logic [7:0] periph_req_o
);
    // quiet lines from time zero
    initial begin
        timer0_rollover_o = 1'b0;
        ext_pin_o = 1'b0;
        pin_level_o = 4'h0;
        periph_req_o = 8'h00;
    end
    // one-cycle pulse on the timer0 rollover line
    task automatic pulse_timer0();
        @(posedge clk_sys_i);
        timer0_rollover_o <= 1'b1;
        @(posedge clk_sys_i);
        timer0_rollover_o <= 1'b0;
    endtask : pulse_timer0
    // levels move right after an edge and hold until the next call
    task automatic drive_lines(input logic ext, input logic [3:0] pins, input logic [7:0] req);
        @(posedge clk_sys_i);
        ext_pin_o <= ext;
        pin_level_o <= pins;
        periph_req_o <= req;
    endtask : drive_lines
endmodule : irq_source_model
